// [rtl/maint_filter_pkg.sv]
// Constants for the maintenance bit filter: APB map, fields, reset values.
// Assumes a single 100 MHz clock and an APB master with 32-bit data.
// Contract
// R1: dual mode interrupts only on two-superframe stable change
// R2: dual mode register shows only twice-seen values
// R3: reset clears byte; software may preload when unlocked
// R4: regained lock reloads programmed initial byte
// R5: verified act follows M40 dual consecutive
// R6: verified dea follows inverted M41, NT only
// R7: lock rising edge clears both verified flags
// R8: default mode: transparency = verified act OR enable
// R9: default mode: deactivate = verified dea OR request
// R10: verified act/dea readable at status bits 2:1
// R11: delta mode updates and interrupts on any change
// R12: every mode stores each byte, interrupts each superframe
// R13: byte register frozen while lock is low
// R14: config bit0 selects trinal check for act/dea/sai/uoa
// R15: M5/M6 filters use 0x dual, 10 delta, 11 every
// R16: M5/M6 interrupt after basic frame four received
// R17: febe from nebe AND input, or input alone
// R18: febe and nebe are active low
// R19: M4 mode 00 verified dual, 01 dual, 10 delta, 11 every
// R20: no load or interrupt unless linkup and lock
// R21: assemble M4 byte, evaluate once per superframe
package maint_filter_pkg;
    // =========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] ADDR_RX_MAINT    = 8'h00;
    localparam logic [7:0] ADDR_LINE_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MODE_CTRL   = 8'h08;
    localparam logic [7:0] ADDR_LINK_CTRL   = 8'h0c;
    localparam logic [7:0] ADDR_OVL_CFG     = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h14;
    localparam logic [7:0] ADDR_M56_STATUS  = 8'h18;
    localparam logic [7:0] ADDR_TX_MAINT    = 8'h1c;
    // =========================================================
    // Field positions
    localparam int M4_MODE_LO   = 4;
    localparam int M56_MODE_LO  = 2;
    localparam int FEBE_CTL_BIT = 0;
    localparam int ACT_BIT      = 0;
    localparam int DEA_BIT      = 1;
    localparam int SAI_UOA_BIT  = 6;
    localparam int VACT_BIT     = 2;
    localparam int VDEA_BIT     = 1;
    localparam int NEBE_BIT     = 3;
    localparam int FEBE_IN_BIT  = 4;
    localparam int CUST_EN_BIT  = 0;
    localparam int DEACT_RQ_BIT = 2;
    localparam int M56_FRAME    = 4;
    // =========================================================
    // Mode codes and reset values
    localparam logic [1:0] MODE_DUAL_VER = 2'b00;
    localparam logic [1:0] MODE_DUAL     = 2'b01;
    localparam logic [1:0] MODE_DELTA    = 2'b10;
    localparam logic [1:0] MODE_EVERY    = 2'b11;
    localparam logic [7:0] BYTE_RESET    = 8'h00;
    localparam logic [7:0] TX_RESET      = 8'hff;
    localparam logic [2:0] M56_RESET     = 3'b000;
    localparam logic [3:0] NIB_RESET     = 4'h0;
endpackage : maint_filter_pkg

// [rtl/maint_filter.sv]
// Maintenance bit filter: M4 byte and M5/M6 bit filtering, verified
// act/dea, febe selection, APB register access.
// Deframer supplies per-bit strobes synchronous to clk_in.
`timescale 1ns/100ps
`default_nettype none
module maint_filter
    import maint_filter_pkg::*;
(
    input  wire logic       clk_in,        // 100 MHz clock
    input  wire logic       rst_in,        // Sync reset, high
    input  wire logic       soft_rst_in,   // Software reset, high
    input  wire logic       nt_mode_in,    // 1 = NT, 0 = LT
    input  wire logic       linkup_in,     // Link established
    input  wire logic       sf_lock_in,    // Superframe lock
    input  wire logic       m4_valid_in,   // M4 bit strobe
    input  wire logic [2:0] m4_idx_in,     // M4 bit position
    input  wire logic       m4_bit_in,     // M4 bit value
    input  wire logic       sf_end_in,     // Superframe complete
    input  wire logic       frame4_end_in, // Basic frame 4 done
    input  wire logic [2:0] m56_bits_in,   // M60,M51,M50
    input  wire logic       nebe_n_in,     // Computed nebe, low=err
    input  wire logic       psel_in,       // APB select
    input  wire logic       penable_in,    // APB enable
    input  wire logic       pwrite_in,     // APB write
    input  wire logic [7:0] paddr_in,      // APB address
    input  wire logic [31:0] pwdata_in,    // APB write data
    output logic [31:0]     prdata_out,    // APB read data
    output logic            pready_out,    // APB ready
    output logic            pslverr_out,   // APB error
    output logic            maint4_irq_out,  // M4 event pulse
    output logic            maint56_irq_out, // M5/M6 event pulse
    output logic            cust_transp_out, // Customer data enable
    output logic            deact_out,       // Respond to deactivate
    output logic            febe_n_out       // Transmitted febe
);
    // =========================================================
    // Register bus
    logic [7:0] init_byte;
    logic [7:0] rx_byte;
    logic [7:0] mode_ctrl;
    logic [3:0] link_ctrl;
    logic       ovl_cfg;
    logic [7:0] tx_maint;
    logic [1:0] irq_status;
    logic [2:0] m56_val;
    logic       vact;
    logic       vdea;
    logic       any_rst;
    logic       wr_en;
    logic       rd_en;
    logic       unlocked;
    logic       addr_ok;
    assign any_rst  = rst_in | soft_rst_in;
    assign wr_en    = psel_in & penable_in & pwrite_in;
    assign rd_en    = psel_in & penable_in & ~pwrite_in;
    assign unlocked = ~linkup_in | ~sf_lock_in;
    always_comb begin
        case (paddr_in)
            ADDR_RX_MAINT, ADDR_LINE_STATUS, ADDR_MODE_CTRL,
            ADDR_LINK_CTRL, ADDR_OVL_CFG, ADDR_IRQ_STATUS,
            ADDR_M56_STATUS, ADDR_TX_MAINT: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // Zero wait states; error on unmapped address
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out  <= psel_in & ~penable_in;
            pslverr_out <= psel_in & ~penable_in & ~addr_ok;
        end
    end

    always_ff @(posedge clk_in) begin
        if (any_rst) begin
            mode_ctrl <= BYTE_RESET;
            link_ctrl <= NIB_RESET;
            ovl_cfg   <= 1'b0;
            tx_maint  <= TX_RESET;
        end else if (wr_en && pready_out) begin
            case (paddr_in)
                ADDR_MODE_CTRL: mode_ctrl <= pwdata_in[7:0];
                ADDR_LINK_CTRL: link_ctrl <= pwdata_in[3:0];
                ADDR_OVL_CFG:   ovl_cfg   <= pwdata_in[0];
                ADDR_TX_MAINT:  tx_maint  <= pwdata_in[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (psel_in && !penable_in && !pwrite_in) begin
            case (paddr_in)
                ADDR_RX_MAINT:    prdata_out <= {24'h0, rx_byte};
                ADDR_LINE_STATUS: prdata_out <= {28'h0, ~nebe_n_in,
                                   vact, vdea, sf_lock_in}; // R10
                ADDR_MODE_CTRL:   prdata_out <= {24'h0, mode_ctrl};
                ADDR_LINK_CTRL:   prdata_out <= {28'h0, link_ctrl};
                ADDR_OVL_CFG:     prdata_out <= {31'h0, ovl_cfg};
                ADDR_IRQ_STATUS:  prdata_out <= {30'h0, irq_status};
                ADDR_M56_STATUS:  prdata_out <= {29'h0, m56_val};
                ADDR_TX_MAINT:    prdata_out <= {24'h0, tx_maint};
                default:          prdata_out <= 32'h0000_0000;
            endcase
        end
    end

    // =========================================================
    // M4 byte assembly
    logic [7:0] asm_byte;
    logic [7:0] next_asm;
    logic       sf_done;
    always_comb begin
        next_asm = asm_byte;
        if (m4_valid_in) begin
            next_asm[m4_idx_in] = m4_bit_in; // R21
        end
    end
    always_ff @(posedge clk_in) begin
        if (any_rst) begin
            asm_byte <= BYTE_RESET;
            sf_done  <= 1'b0;
        end else begin
            asm_byte <= next_asm;
            sf_done  <= sf_end_in; // R21
        end
    end

    // =========================================================
    // M4 filtering
    logic [1:0] m4_mode;
    logic [7:0] prev_byte;
    logic [7:0] older_byte;
    logic       hist_ok;
    logic       hist2_ok;
    logic       lock_d;
    logic       lock_rise;
    logic [7:0] next_rx;
    logic       next_irq4;
    logic       eval_ok;
    assign m4_mode   = mode_ctrl[M4_MODE_LO +: 2];
    assign lock_rise = sf_lock_in & ~lock_d;
    assign eval_ok   = sf_done & linkup_in & sf_lock_in; // R20

    always_comb begin
        next_rx   = rx_byte;
        next_irq4 = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (ovl_cfg && (i == ACT_BIT || i == DEA_BIT ||
                            i == SAI_UOA_BIT)) begin
                // Trinal check: three matching superframes
                if (hist2_ok && asm_byte[i] == prev_byte[i] &&
                    prev_byte[i] == older_byte[i]) begin
                    next_rx[i] = asm_byte[i]; // R14
                end
            end else begin
                case (m4_mode)
                    MODE_DELTA, MODE_EVERY: begin
                        if (m4_mode == MODE_EVERY || !hist_ok ||
                            asm_byte != prev_byte) begin
                            next_rx[i] = asm_byte[i]; // R11 R12 R19
                        end
                    end
                    default: begin
                        if (hist_ok && asm_byte[i] == prev_byte[i]) begin
                            next_rx[i] = asm_byte[i]; // R2 R19
                        end
                    end
                endcase
            end
        end
        case (m4_mode)
            MODE_EVERY: next_irq4 = 1'b1; // R12
            MODE_DELTA: next_irq4 = hist_ok &&
                                    (asm_byte != prev_byte); // R11
            default:    next_irq4 = (next_rx != rx_byte); // R1
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (any_rst) begin
            init_byte <= BYTE_RESET;
        end else if (wr_en && pready_out && unlocked &&
                     paddr_in == ADDR_RX_MAINT) begin
            init_byte <= pwdata_in[7:0]; // R3
        end
    end

    always_ff @(posedge clk_in) begin
        if (any_rst) begin
            rx_byte <= BYTE_RESET; // R3
        end else if (wr_en && pready_out && unlocked &&
                     paddr_in == ADDR_RX_MAINT) begin
            rx_byte <= pwdata_in[7:0]; // R3
        end else if (lock_rise) begin
            rx_byte <= init_byte; // R4
        end else if (eval_ok) begin
            rx_byte <= next_rx; // R13 R20
        end
    end

    always_ff @(posedge clk_in) begin
        if (any_rst) begin
            prev_byte  <= BYTE_RESET;
            older_byte <= BYTE_RESET;
            hist_ok    <= 1'b0;
            hist2_ok   <= 1'b0;
            lock_d     <= 1'b0;
            maint4_irq_out <= 1'b0;
        end else begin
            lock_d <= sf_lock_in;
            maint4_irq_out <= eval_ok & next_irq4; // R20
            if (!sf_lock_in || !linkup_in) begin
                hist_ok  <= 1'b0;
                hist2_ok <= 1'b0;
            end else if (sf_done) begin
                prev_byte  <= asm_byte;
                older_byte <= prev_byte;
                hist_ok    <= 1'b1;
                hist2_ok   <= hist_ok;
            end
        end
    end

    // =========================================================
    // Verified act / dea, default mode only
    always_ff @(posedge clk_in) begin
        if (any_rst || lock_rise) begin
            vact <= 1'b0; // R7
            vdea <= 1'b0; // R7
        end else if (eval_ok && m4_mode == MODE_DUAL_VER) begin
            if (hist_ok && asm_byte[ACT_BIT] == prev_byte[ACT_BIT]) begin
                vact <= asm_byte[ACT_BIT]; // R5
            end
            if (nt_mode_in && hist_ok &&
                asm_byte[DEA_BIT] == prev_byte[DEA_BIT]) begin
                vdea <= ~asm_byte[DEA_BIT]; // R6
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (any_rst) begin
            cust_transp_out <= 1'b0;
            deact_out       <= 1'b0;
        end else if (m4_mode == MODE_DUAL_VER) begin
            cust_transp_out <= vact | link_ctrl[CUST_EN_BIT]; // R8
            deact_out       <= vdea | link_ctrl[DEACT_RQ_BIT]; // R9
        end else begin
            cust_transp_out <= link_ctrl[CUST_EN_BIT];
            deact_out       <= link_ctrl[DEACT_RQ_BIT];
        end
    end

    // =========================================================
    // M5/M6 filtering, evaluated at end of basic frame 4
    logic [1:0] m56_mode;
    logic [2:0] m56_prev;
    logic       m56_hist;
    logic [2:0] next_m56;
    logic       next_irq56;
    logic       m56_ok;
    assign m56_mode = mode_ctrl[M56_MODE_LO +: 2];
    assign m56_ok   = frame4_end_in & linkup_in & sf_lock_in; // R16
    always_comb begin
        next_m56   = m56_val;
        next_irq56 = 1'b0;
        case (m56_mode)
            MODE_EVERY: begin
                next_m56   = m56_bits_in; // R15
                next_irq56 = 1'b1;
            end
            MODE_DELTA: begin
                if (!m56_hist || m56_bits_in != m56_prev) begin
                    next_m56 = m56_bits_in; // R15
                end
                next_irq56 = m56_hist && (m56_bits_in != m56_prev);
            end
            default: begin
                for (int i = 0; i < 3; i++) begin
                    if (m56_hist && m56_bits_in[i] == m56_prev[i]) begin
                        next_m56[i] = m56_bits_in[i]; // R15
                    end
                end
                next_irq56 = (next_m56 != m56_val);
            end
        endcase
    end
    always_ff @(posedge clk_in) begin
        if (any_rst) begin
            m56_val  <= M56_RESET;
            m56_prev <= M56_RESET;
            m56_hist <= 1'b0;
            maint56_irq_out <= 1'b0;
        end else begin
            maint56_irq_out <= m56_ok & next_irq56; // R16
            if (!sf_lock_in || !linkup_in) begin
                m56_hist <= 1'b0;
            end else if (frame4_end_in) begin
                m56_val  <= next_m56;
                m56_prev <= m56_bits_in;
                m56_hist <= 1'b1;
            end
        end
    end

    // Sticky copy for software; a new pulse wins over a clear
    always_ff @(posedge clk_in) begin
        if (any_rst) begin
            irq_status <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == 0 ? maint56_irq_out : maint4_irq_out)) begin
                    irq_status[i] <= 1'b1;
                end else if (wr_en && pready_out &&
                             paddr_in == ADDR_IRQ_STATUS &&
                             pwdata_in[i]) begin
                    irq_status[i] <= 1'b0;
                end
            end
        end
    end

    // =========================================================
    // Transmitted febe, active low
    always_ff @(posedge clk_in) begin
        if (any_rst) begin
            febe_n_out <= 1'b1;
        end else if (mode_ctrl[FEBE_CTL_BIT]) begin
            febe_n_out <= tx_maint[FEBE_IN_BIT]; // R17
        end else begin
            febe_n_out <= nebe_n_in & tx_maint[FEBE_IN_BIT]; // R17 R18
        end
    end

    // =========================================================
    // Checks
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_every_irq: assert property ( // R12
        (eval_ok && m4_mode == MODE_EVERY && !lock_rise && !soft_rst_in)
        |=> maint4_irq_out) else $error("missed irq");
    a_frozen_unlock: assert property ( // R13
        disable iff (rst_in || soft_rst_in)
        (!sf_lock_in && !wr_en && $past(!sf_lock_in)) |=>
        $stable(rx_byte)) else $error("byte changed");
    a_no_irq_unlocked: assert property ( // R20
        (!linkup_in || !sf_lock_in) |=> !maint4_irq_out)
        else $error("irq unlocked");
    a_lock_clears: assert property ( // R7
        lock_rise |=> (!vact && !vdea)) else $error("flags kept");
    a_febe_pass: assert property ( // R17
        disable iff (rst_in || soft_rst_in)
        $past(mode_ctrl[FEBE_CTL_BIT]) |->
        febe_n_out == $past(tx_maint[FEBE_IN_BIT]))
        else $error("febe wrong");
    a_febe_err: assert property ( // R18
        disable iff (rst_in || soft_rst_in)
        (!nebe_n_in && !mode_ctrl[FEBE_CTL_BIT]) |=> !febe_n_out)
        else $error("nebe lost");
    a_transp_or: assert property ( // R8
        disable iff (rst_in || soft_rst_in)
        (m4_mode == MODE_DUAL_VER && vact) |=> cust_transp_out)
        else $error("no transparency");
    a_deact_or: assert property ( // R9
        disable iff (rst_in || soft_rst_in)
        (m4_mode == MODE_DUAL_VER && vdea) |=> deact_out)
        else $error("no deactivate");
    a_lt_no_dea: assert property ( // R6
        (!nt_mode_in && !vdea) |=> !vdea) else $error("dea in LT");
    a_m56_timing: assert property ( // R16
        maint56_irq_out |-> $past(frame4_end_in))
        else $error("m56 irq late");

endmodule : maint_filter
`default_nettype wire

// [bench/remote_m4_sender.sv]
// Far-end model: sends one superframe of M4 bits, M5/M6 bits mid-frame.
// Assumes go_in is a one-cycle pulse given while busy_out is low.
`timescale 1ns/100ps
`default_nettype none
module remote_m4_sender (
    input  wire logic       clk_in,    // Bench clock
    input  wire logic       go_in,     // Start one superframe
    input  wire logic [7:0] byte_in,   // M4 byte to send
    input  wire logic [2:0] m56_in,    // M60,M51,M50
    input  wire logic [2:0] gap_in,    // Idle cycles per step
    output logic            busy_out,  // Superframe in flight
    output logic            valid_out, // M4 bit strobe
    output logic [2:0]      idx_out,   // M4 bit position
    output logic            bit_out,   // M4 bit value
    output logic            f4_out,    // Basic frame 4 done
    output logic [2:0]      m56_out,   // M5/M6 bits
    output logic            end_out    // Superframe done
);
    logic [3:0] step   = 4'h0;
    logic [2:0] wait_c = 3'h0;
    logic [7:0] sb     = 8'h00;
    logic [2:0] sm     = 3'h0;
    wire logic       fire = busy_out && wait_c == 3'h0;
    wire logic [2:0] pos  = (step < 4'h4) ? step[2:0] : 3'(step - 4'h1);
    initial {busy_out, bit_out, m56_out} = '0;
    // =========================================================
    // Steps 0-3 and 5-8 carry bits, 4 closes basic frame four, 9 ends.
    always @(posedge clk_in) begin
        valid_out <= fire && step != 4'h4 && step != 4'h9;
        f4_out    <= fire && step == 4'h4;
        end_out   <= fire && step == 4'h9;
        idx_out   <= pos;
        bit_out   <= (fire && step != 4'h4) ? sb[pos] : ~bit_out;
        m56_out   <= (fire && step == 4'h4) ? sm : m56_out + 3'h1;
        wait_c    <= (fire || !busy_out) ? gap_in : wait_c - 3'h1;
        if (!busy_out && go_in === 1'b1) begin
            busy_out <= 1'b1;
            step     <= 4'h0;
            sb       <= byte_in;
            sm       <= m56_in;
        end else if (fire) begin
            step     <= step + 4'h1;
            busy_out <= step != 4'h9;
        end
    end
endmodule : remote_m4_sender
`default_nettype wire

// [bench/maint_filter_test.sv]
// Testbench for maint_filter: APB master, far-end model, bench model.
// Assumes one 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module maint_filter_test;
    import maint_filter_pkg::*;
    logic        clk_in = 0, rst_in = 1, soft_rst_in = 0, nt_mode_in = 1;
    logic        linkup_in = 0, sf_lock_in = 0, nebe_n_in = 1;
    logic        psel_in = 0, penable_in = 0, pwrite_in = 0;
    logic [7:0]  paddr_in = 8'h00, sf_byte = 8'h00;
    logic [31:0] pwdata_in = 32'h0, prdata_out;
    logic        pready_out, pslverr_out, maint4_irq_out, maint56_irq_out;
    logic        cust_transp_out, deact_out, febe_n_out, sf_go = 0;
    logic [2:0]  sf_m56 = 3'h0, sf_gap = 3'h0;
    wire logic       m4_valid_in, m4_bit_in, sf_end_in, frame4_end_in, sf_busy;
    wire logic [2:0] m4_idx_in, m56_bits_in;
    int err_total = 0, check_count = 0, cycles = 0, irq4 = 0, irq56 = 0;
    int m_reg, m_init, m_prev, m_hist, m5_reg, m5_prev, vact, vdea;
    int mode4, mode56, cust, drq;
    maint_filter i_maint_filter (.*);
    remote_m4_sender i_remote_m4_sender (.clk_in(clk_in), .go_in(sf_go),
        .byte_in(sf_byte), .m56_in(sf_m56), .gap_in(sf_gap),
        .busy_out(sf_busy), .valid_out(m4_valid_in), .idx_out(m4_idx_in),
        .bit_out(m4_bit_in), .f4_out(frame4_end_in), .m56_out(m56_bits_in),
        .end_out(sf_end_in));
    initial forever #5 clk_in = ~clk_in;
    // =========================================================
    // Counters
    always @(posedge clk_in) begin
        cycles++;
        if (maint4_irq_out === 1'b1) irq4++;
        if (maint56_irq_out === 1'b1) irq56++;
        if (cycles == 30000) begin
            err_total++;
            $display("Timeout");
            summarize();
        end
    end
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // =========================================================
    // APB master
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge clk_in);
        psel_in    <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in  <= w;
        paddr_in   <= a;
        pwdata_in  <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do @(negedge clk_in); while (pready_out !== 1'b1);
        q = prdata_out;
        e = pslverr_out;
        @(posedge clk_in);
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask : rd
    // =========================================================
    // Bench model
    function automatic int filt(int md, int hist, int prev, int r, int b,
                                int mask);
        int same;
        same = hist ? ~(b ^ prev) & mask : 0;
        if (md == 3 || (md == 2 && (!hist || b != prev))) return b;
        if (md < 2) return (r & ~same) | (b & same);
        return r;
    endfunction : filt
    function automatic int irq_exp(int md, int hist, int prev, int b,
                                   int old, int nw);
        return md == 3 || (hist && (md == 2 ? b != prev : nw != old));
    endfunction : irq_exp
    task automatic mreset();
        {m_reg, m_init, m_prev, m_hist, m5_reg, m5_prev} = '0;
        {vact, vdea, mode4, mode56, cust, drq} = '0;
    endtask : mreset
    task automatic set_mode(input int m4, input int m56);
        mode4  = m4;
        mode56 = m56;
        wr(ADDR_MODE_CTRL, 32'(m4 * 16 + m56 * 4));
    endtask : set_mode
    task automatic set_up(input logic lk, input logic lu);
        @(posedge clk_in);
        if (lk && !sf_lock_in) begin
            m_reg = m_init;
            vact  = 0;
            vdea  = 0;
        end
        if (!(lk && lu)) m_hist = 0;
        sf_lock_in <= lk;
        linkup_in  <= lu;
        repeat (3) @(posedge clk_in);
    endtask : set_up
    task automatic status();
        logic [31:0] q;
        rd(ADDR_LINE_STATUS, q);
        check("line status", q,
              32'({!nebe_n_in, vact[0], vdea[0], sf_lock_in}));
        check("transparency", cust_transp_out, 32'(cust | vact));
        check("deactivate", deact_out, 32'(drq | vdea));
    endtask : status
    task automatic sf(input int b, input int m);
        int          i4, i5, n4, n5, old, up;
        logic [31:0] q;
        i4 = irq4;
        i5 = irq56;
        up = linkup_in && sf_lock_in;
        @(posedge clk_in);
        sf_byte <= 8'(b);
        sf_m56  <= 3'(m);
        sf_gap  <= 3'($urandom_range(3, 0));
        sf_go   <= 1'b1;
        @(posedge clk_in);
        sf_go <= 1'b0;
        do @(negedge clk_in); while (sf_busy === 1'b1);
        repeat (4) @(posedge clk_in);
        n4 = 0;
        if (up) begin
            old   = m_reg;
            m_reg = filt(mode4, m_hist, m_prev, m_reg, b, 255);
            n4    = irq_exp(mode4, m_hist, m_prev, b, old, m_reg);
            if (mode4 == 0 && m_hist && ((b ^ m_prev) & 1) == 0) vact = b & 1;
            if (mode4 == 0 && m_hist && nt_mode_in && ((b ^ m_prev) & 2) == 0)
                vdea = ((b >> 1) & 1) ^ 1;
            old    = m5_reg;
            m5_reg = filt(mode56, m_hist, m5_prev, m5_reg, m, 7);
            n5     = irq_exp(mode56, m_hist, m5_prev, m, old, m5_reg);
            check("m56 irq count", 32'(irq56 - i5), 32'(n5));
            rd(ADDR_M56_STATUS, q);
            check("m56 value", q, 32'(m5_reg));
            m_prev  = b;
            m5_prev = m;
            m_hist  = 1;
        end
        check("m4 irq count", 32'(irq4 - i4), 32'(n4));
        rd(ADDR_RX_MAINT, q);
        check("rx byte", q, 32'(m_reg));
        if (mode4 == 0) status();
    endtask : sf
    // =========================================================
    // Main sequence
    initial begin : main
        logic [31:0] q;
        logic        e;
        int          seq[] = '{0, 0, 'h81, 'h11, 1, 3, 3, 0, 0};
        void'($urandom(28));
        mreset();
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(ADDR_RX_MAINT, q);
        check("rx reset", q, 32'h0);
        rd(ADDR_TX_MAINT, q);
        check("tx reset", q, 32'hff);
        apb(1'b0, 8'h20, 32'h0, q, e);
        check("unmapped error", e, 32'h1);
        check("unmapped data", q, 32'h0);
        for (int k = 0; k < 8; k++) begin
            wr(ADDR_MODE_CTRL, 32'(k & 1));
            wr(ADDR_TX_MAINT, k[1] ? 32'hff : 32'hef);
            nebe_n_in <= k[2];
            repeat (3) @(negedge clk_in);
            check("febe", febe_n_out, 32'(k[0] ? k[1] : k[1] & k[2]));
            rd(ADDR_LINE_STATUS, q);
            check("nebe status", q[3], 32'(!k[2]));
        end
        set_mode(0, 0);
        $display("Test febe done");
        wr(ADDR_RX_MAINT, 32'h3c);
        rd(ADDR_RX_MAINT, q);
        check("preload", q, 32'h3c);
        @(posedge clk_in);
        soft_rst_in <= 1'b1;
        @(posedge clk_in);
        soft_rst_in <= 1'b0;
        mreset();
        rd(ADDR_RX_MAINT, q);
        check("soft reset", q, 32'h0);
        $display("Test preload done");
        set_up(1'b1, 1'b1);
        foreach (seq[i]) sf(seq[i], i & 7);
        cust = 1;
        drq  = 1;
        wr(ADDR_LINK_CTRL, 32'h5);
        status();
        cust = 0;
        drq  = 0;
        wr(ADDR_LINK_CTRL, 32'h0);
        repeat (6) sf($urandom_range(255, 0), $urandom_range(7, 0));
        $display("Test dual done");
        set_up(1'b0, 1'b0);
        sf('h55, m5_reg);
        wr(ADDR_RX_MAINT, 32'ha5);
        m_init = 'ha5;
        m_reg  = 'ha5;
        set_up(1'b1, 1'b1);
        rd(ADDR_RX_MAINT, q);
        check("reload", q, 32'ha5);
        status();
        wr(ADDR_RX_MAINT, 32'h0f);
        rd(ADDR_RX_MAINT, q);
        check("locked write", q, 32'ha5);
        $display("Test reload done");
        for (int k = 0; k < 4; k++) begin
            set_mode(k == 0 ? 1 : k, k);
            repeat (6) begin
                if ($urandom_range(1, 0)) sf(m_prev, m5_prev);
                else sf($urandom_range(255, 0), $urandom_range(7, 0));
            end
            $display("Test mode %0d done", k);
        end
        set_up(1'b1, 1'b0);
        sf('h77, m5_reg);
        nt_mode_in <= 1'b0;
        set_up(1'b0, 1'b0);
        set_up(1'b1, 1'b1);
        set_mode(0, 0);
        foreach (seq[i]) sf(seq[i], 0);
        $display("Test LT done");
        summarize();
    end
endmodule : maint_filter_test
`default_nettype wire
